// [ior_consts.vh]
`ifndef IOR_CONSTS_VH
`define IOR_CONSTS_VH
// ==========================================
// Instruction word layout (12-bit)
`define IOR_WORD_W 12
`define IOR_DATA_W 8
`define IOR_ADDR_W 5
// Register OR: 0001 00df ffff
// Opcode field stops above the destination bit
`define IOR_RWF_OPC 6'h04
`define IOR_RWF_OPC_HI 11
`define IOR_RWF_OPC_LO 6
`define IOR_DEST_BIT 5
`define IOR_ADDR_HI 4
`define IOR_ADDR_LO 0
// Literal OR: 1101 kkkk kkkk
`define IOR_RLW_OPC 4'hD
`define IOR_RLW_OPC_HI 11
`define IOR_RLW_OPC_LO 8
`define IOR_LIT_HI 7
`define IOR_LIT_LO 0
// Reset values
`define IOR_ACC_RST 8'h00
`define IOR_NULL_RST 1'h0
`endif

// [ior_logic_unit.v]
`timescale 1ns/1ns
`default_nettype none
`include "ior_consts.vh"
// ==========================================
// Combinational OR with null detect
module ior_logic_unit #(
	parameter WIDTH = `IOR_DATA_W
) (
	// Operands
	input wire [WIDTH-1:0] i_a,
	input wire [WIDTH-1:0] i_b,
	// Result
	output wire [WIDTH-1:0] o_result,
	output wire o_null
);
	// Per-bit OR, one generate loop
	genvar g;
	generate
		for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
			assign o_result[g] = i_a[g] | i_b[g];
		end
	endgenerate
	// Null flag on all-zero result
	assign o_null = ~|o_result;
endmodule
`default_nettype wire

// [ior_datapath.v]
// Operation
// - Literal OR ORs accumulator with instruction literal, result into accumulator.
// - Register OR computes accumulator OR addressed data register contents.
// - Register OR with destination bit 0 writes accumulator, register untouched.
// - Register OR with destination bit 1 writes back to addressed register.
`timescale 1ns/1ns
`default_nettype none
`include "ior_consts.vh"
module ior_datapath #(
	parameter DATA_W = `IOR_DATA_W,
	parameter ADDR_W = `IOR_ADDR_W
) (
	// Clock, reset, enable
	input wire i_clock,
	input wire i_nrst,
	input wire i_clk_en,
	// Instruction issue
	input wire i_valid,
	input wire [`IOR_WORD_W-1:0] i_instr,
	// Register file read port, same-clock combinational data
	output wire [ADDR_W-1:0] o_rd_addr,
	input wire [DATA_W-1:0] i_rd_data,
	// Register file write port
	output reg o_wr_en,
	output reg [ADDR_W-1:0] o_wr_addr,
	output reg [DATA_W-1:0] o_wr_data,
	// Core state
	output reg [DATA_W-1:0] o_acc,
	output reg o_null,
	output reg o_done
);
	// ==========================================
	// Field widths
	// Taken from the field positions so a moved field stays self-consistent
	localparam RLW_OPC_W = `IOR_RLW_OPC_HI - `IOR_RLW_OPC_LO + 1;
	localparam RWF_OPC_W = `IOR_RWF_OPC_HI - `IOR_RWF_OPC_LO + 1;
	localparam LIT_W = `IOR_LIT_HI - `IOR_LIT_LO + 1;
	localparam FADDR_W = `IOR_ADDR_HI - `IOR_ADDR_LO + 1;

	// ==========================================
	// Instruction fields
	// Register OR: opcode, destination bit, five-bit register address
	// Literal OR: opcode and eight-bit literal
	wire [RLW_OPC_W-1:0] rlw_opc_field;
	wire [RWF_OPC_W-1:0] rwf_opc_field;
	wire [LIT_W-1:0] lit_field;
	wire [FADDR_W-1:0] addr_field;
	wire dest_field;

	// Plain slices of the issued word; nothing is latched here
	assign rlw_opc_field = i_instr[`IOR_RLW_OPC_HI:`IOR_RLW_OPC_LO];
	assign rwf_opc_field = i_instr[`IOR_RWF_OPC_HI:`IOR_RWF_OPC_LO];
	assign lit_field = i_instr[`IOR_LIT_HI:`IOR_LIT_LO];
	assign addr_field = i_instr[`IOR_ADDR_HI:`IOR_ADDR_LO];
	assign dest_field = i_instr[`IOR_DEST_BIT];

	// ==========================================
	// Instruction class decode
	wire rlw_match;
	wire rwf_match;
	wire is_rlw;
	wire is_rwf;

	// The two opcodes are disjoint, so at most one matches
	// Destination bit lies below the register OR opcode field
	assign rlw_match = (rlw_opc_field == `IOR_RLW_OPC);
	assign rwf_match = (rwf_opc_field == `IOR_RWF_OPC);

	// Valid qualifies the decode; enable is applied at the registers
	assign is_rlw = i_valid && rlw_match;
	assign is_rwf = i_valid && rwf_match;

	// ==========================================
	// One-hot instruction class
	// One-hot keeps each commit case a single-bit compare
	localparam CLS_IDLE = 4'h1;
	localparam CLS_LIT = 4'h2;
	localparam CLS_REG_ACC = 4'h4;
	localparam CLS_REG_FILE = 4'h8;
	reg [3:0] op_class;

	// Class of the word on the bus this cycle; foreign words stay idle
	always @* begin
		op_class = CLS_IDLE;
		if (is_rlw) begin
			op_class = CLS_LIT;
		end else if (is_rwf && dest_field) begin
			op_class = CLS_REG_FILE;
		end else if (is_rwf) begin
			op_class = CLS_REG_ACC;
		end
	end

	// ==========================================
	// Register file read port
	// Address is a pure decode so the read returns in the same cycle.
	// Limitation: the one output not taken from a flip-flop.
	assign o_rd_addr = addr_field;

	// ==========================================
	// Operand select
	wire [DATA_W-1:0] lit_operand;
	wire [DATA_W-1:0] operand;

	// Literal fills the data width exactly at the default sizes
	assign lit_operand = lit_field;
	// Literal for the literal OR, file contents otherwise
	assign operand = is_rlw ? lit_operand : i_rd_data;

	// ==========================================
	// OR unit
	wire [DATA_W-1:0] result;
	wire result_null;

	// Accumulator feeds back directly, so back-to-back ORs chain
	ior_logic_unit #(
		.WIDTH(DATA_W)
	) u_or (
		.i_a(o_acc),
		.i_b(operand),
		.o_result(result),
		.o_null(result_null)
	);

	// ==========================================
	// Next-state values
	reg [DATA_W-1:0] next_acc;
	reg next_null;
	reg next_wr_en;
	reg [ADDR_W-1:0] next_wr_addr;
	reg [DATA_W-1:0] next_wr_data;
	reg next_done;

	// Default is hold; strobe and done fall unless a class raises them
	always @* begin
		next_acc = o_acc;
		next_null = o_null;
		next_wr_en = 1'h0; // No write unless the file is the target
		next_wr_addr = o_wr_addr;
		next_wr_data = o_wr_data;
		next_done = 1'h0;
		case (op_class)
			CLS_LIT: begin
				next_acc = result;
				next_null = result_null;
				next_done = 1'h1;
			end

			CLS_REG_ACC: begin
				next_acc = result;
				next_null = result_null;
				next_done = 1'h1;
			end

			CLS_REG_FILE: begin
				// Accumulator kept; result goes back to the file
				next_wr_en = 1'h1;
				next_wr_addr = o_rd_addr;
				next_wr_data = result;
				next_null = result_null;
				next_done = 1'h1;
			end

			default: begin
				// Idle or foreign opcode: no strobe, state held
				next_done = 1'h0;
			end
		endcase
	end

	// ==========================================
	// Commit registers
	// Each register retires on one enabled edge. Enable low freezes all of
	// them, pulses included, so a stalled core still sees a raised pulse.

	// Accumulator; reset leaves it empty
	always @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			o_acc <= `IOR_ACC_RST;
		end else if (i_clk_en) begin
			o_acc <= next_acc;
		end
	end

	// Null flag; also written on write-back, so a file value can be tested
	always @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			o_null <= `IOR_NULL_RST;
		end else if (i_clk_en) begin
			o_null <= next_null;
		end
	end

	// Write port: strobe, address and data move together.
	// Hazard: the file sees the write one cycle after the word is taken,
	// so a register OR of the same register on the next cycle reads the
	// old value unless the register file forwards.
	always @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			o_wr_en <= 1'h0;
			o_wr_addr <= {ADDR_W{1'h0}};
			o_wr_data <= {DATA_W{1'h0}};
		end else if (i_clk_en) begin
			o_wr_en <= next_wr_en;
			o_wr_addr <= next_wr_addr;
			o_wr_data <= next_wr_data;
		end
	end

	// Retire pulse for the core's sequencing
	always @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			o_done <= 1'h0;
		end else if (i_clk_en) begin
			o_done <= next_done;
		end
	end
endmodule
`default_nettype wire

// [ior_properties.sv]
`timescale 1ns/1ns
`default_nettype none
// ==========
// Port checks for the OR datapath
module ior_chk (
	input wire i_clock, i_nrst, i_clk_en, i_valid, o_wr_en, o_null, o_done,
	input wire [11:0] i_instr,
	input wire [7:0] i_rd_data, o_wr_data, o_acc,
	input wire [4:0] o_rd_addr, o_wr_addr
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_nrst);
	wire go = i_valid && i_clk_en;
	wire lit = go && i_instr[11:8] == 4'hD;
	wire rwf = go && i_instr[11:6] == 6'h04;
	logic [7:0] x;
	// Result expected one edge after the word is taken
	always @(posedge i_clock) x <= o_acc | (lit ? i_instr[7:0] : i_rd_data);
	property p_lit; lit |=> o_acc == x; endproperty
	a_lit: assert property (p_lit) else $error("literal result wrong");
	property p_reg; rwf |=> (o_wr_en ? o_wr_data : o_acc) == x; endproperty
	a_reg: assert property (p_reg) else $error("register result wrong");
	property p_d0; rwf && !i_instr[5] |=> !o_wr_en && o_acc == x; endproperty
	a_d0: assert property (p_d0) else $error("accumulator target wrong");
	property p_d1; rwf && i_instr[5] |=> o_wr_en && o_wr_addr == $past(o_rd_addr) && $stable(o_acc); endproperty
	a_d1: assert property (p_d1) else $error("write-back wrong");
	property p_z; lit || rwf |=> o_done && o_null == (x == 8'h00); endproperty
	a_z: assert property (p_z) else $error("null flag or done wrong");
	property p_idle; i_clk_en && !lit && !rwf |=> !o_done && !o_wr_en &&
		$stable(o_acc) && $stable(o_null); endproperty
	a_idle: assert property (p_idle) else $error("state moved without an OR");
	property p_freeze; !i_clk_en |=> $stable(o_acc) && $stable(o_null) && $stable(o_done) &&
		$stable(o_wr_en) && $stable(o_wr_addr) && $stable(o_wr_data); endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while enable low");
endmodule
bind ior_datapath ior_chk i_chk (.i_clock(i_clock), .i_nrst(i_nrst), .i_clk_en(i_clk_en), .i_valid(i_valid),
	.o_wr_en(o_wr_en), .o_null(o_null), .o_done(o_done), .i_instr(i_instr), .i_rd_data(i_rd_data),
	.o_wr_data(o_wr_data), .o_acc(o_acc), .o_rd_addr(o_rd_addr), .o_wr_addr(o_wr_addr));
`default_nettype wire

// [tb.sv]
`timescale 1ns/1ns
`default_nettype none
// ==========
// Bench
module tb;
	logic c = 0, nrst = 0, e = 1, v = 0;
	logic [11:0] ins = 0;
	logic [7:0] rd = 0;
	wire [4:0] ra, wa;
	wire [7:0] wd, acc;
	wire we, z, dn;
	int fails = 0, num_checks = 0;
	ior_datapath i_dut (.i_clock(c), .i_nrst(nrst), .i_clk_en(e), .i_valid(v), .i_instr(ins), .o_rd_addr(ra),
		.i_rd_data(rd), .o_wr_en(we), .o_wr_addr(wa), .o_wr_data(wd), .o_acc(acc), .o_null(z), .o_done(dn));
	// One word issued at a falling edge, taken at the next rising edge;
	// state checked while it stands, then an idle cycle must drop the pulses
	task go(input [11:0] i, input [7:0] r, input [15:0] x);
		ins = i;
		rd = r;
		v = 1;
		@(negedge c);
		num_checks++;
		if ({z, dn, we, acc} !== x) begin
			fails++;
			$display("BAD state exp %h got %h", x, {z, dn, we, acc});
		end
		v = 0;
		@(negedge c);
		num_checks++;
		if ({dn, we} !== 2'h0) begin
			fails++;
			$display("BAD pulses exp 0 got %h", {dn, we});
		end
	endtask
	// Literal OR: zero result, then a two-step chain
	task t_literal;
		go(12'hD00, 8'h00, 16'h0600);
		go(12'hD9A, 8'h00, 16'h029A);
		go(12'hD35, 8'h00, 16'h02BF);
	endtask
	// Register OR back to the file: accumulator kept, write port loaded
	task t_reg_writeback;
		go(12'h12F, 8'h40, 16'h03BF);
		num_checks++;
		if ({wa, wd} !== 13'h0FFF) begin
			fails++;
			$display("BAD write exp 0FFF got %h", {wa, wd});
		end
	endtask
	// Register OR into the accumulator: write port left as it was
	task t_reg_to_acc;
		go(12'h103, 8'h40, 16'h02FF);
		num_checks++;
		if ({wa, wd} !== 13'h0FFF) begin
			fails++;
			$display("BAD write kept exp 0FFF got %h", {wa, wd});
		end
	endtask
	// Enable low holds a raised pulse; it falls once enable returns
	task t_freeze;
		ins = 12'hD01;
		rd = 8'h00;
		v = 1;
		@(negedge c);
		num_checks++;
		if ({z, dn, we, acc} !== 11'h2FF) begin
			fails++;
			$display("BAD retire exp 2FF got %h", {z, dn, we, acc});
		end
		e = 0;
		@(negedge c);
		num_checks++;
		if ({z, dn, we, acc} !== 11'h2FF) begin
			fails++;
			$display("BAD frozen exp 2FF got %h", {z, dn, we, acc});
		end
		v = 0;
		e = 1;
		@(negedge c);
		num_checks++;
		if ({z, dn, we, acc} !== 11'h0FF) begin
			fails++;
			$display("BAD thawed exp 0FF got %h", {z, dn, we, acc});
		end
	endtask
	// Foreign opcode with valid high: nothing retires
	task t_refused;
		ins = 12'hC12;
		rd = 8'h00;
		v = 1;
		@(negedge c);
		num_checks++;
		if ({z, dn, we, acc} !== 11'h0FF) begin
			fails++;
			$display("BAD refused exp 0FF got %h", {z, dn, we, acc});
		end
		v = 0;
		@(negedge c);
	endtask
	// Mid-run reset clears every registered output; ORs then start from an empty accumulator
	task t_mid_reset;
		nrst = 0;
		@(negedge c);
		num_checks++;
		if ({z, dn, we, acc, wa, wd} !== 24'h000000) begin
			fails++;
			$display("BAD reset exp 000000 got %h", {z, dn, we, acc, wa, wd});
		end
		nrst = 1;
		go(12'h10F, 8'h00, 16'h0600);
		go(12'h121, 8'h5A, 16'h0300);
		num_checks++;
		if ({wa, wd} !== 13'h015A) begin
			fails++;
			$display("BAD write after reset exp 015A got %h", {wa, wd});
		end
	endtask
	task tally_and_finish;
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial forever #10 c = ~c;
	initial begin
		#20000 fails++;
		tally_and_finish;
	end
	initial begin
		repeat (3) @(negedge c);
		nrst = 1;
		t_literal;
		t_reg_writeback;
		t_reg_to_acc;
		t_freeze;
		t_refused;
		t_mid_reset;
		tally_and_finish;
	end
endmodule
`default_nettype wire
